// ---- hw/frac_pkg.sv ----
// Package for the fuse and ROM access control block.
// Holds register offsets, field positions, opcodes, fuse ranges, reset
// values and timing constants shared by the top module and the fuse bank.
package frac_pkg;

  // Wishbone register byte offsets (32-bit aligned words)
  localparam logic [7:0] FRAC_OFS_CMD    = 8'h00;
  localparam logic [7:0] FRAC_OFS_BURN0  = 8'h04;
  localparam logic [7:0] FRAC_OFS_BURN1  = 8'h08;
  localparam logic [7:0] FRAC_OFS_BURN2  = 8'h0c;
  localparam logic [7:0] FRAC_OFS_CHAL   = 8'h10;
  localparam logic [7:0] FRAC_OFS_RESP   = 8'h14;
  localparam logic [7:0] FRAC_OFS_RESULT = 8'h18;
  localparam logic [7:0] FRAC_OFS_STATUS = 8'h1c;
  localparam logic [7:0] FRAC_OFS_SERLO  = 8'h20;
  localparam logic [7:0] FRAC_OFS_SERHI  = 8'h24;

  // Command register fields
  localparam int FRAC_CMD_OP_LSB  = 0;   // Opcode in bits 3:0
  localparam int FRAC_CMD_ARG_LSB = 8;   // Word address or step in bits 9:8

  // Opcodes
  localparam logic [3:0] FRAC_OP_FUSE_READ = 4'h1;
  localparam logic [3:0] FRAC_OP_BURN      = 4'h2;
  localparam logic [3:0] FRAC_OP_ROM_READ  = 4'h3;
  localparam logic [3:0] FRAC_OP_VALIDATE  = 4'h4;
  localparam logic [3:0] FRAC_OP_WAKE      = 4'h5;

  // Validation steps carried in the argument field
  localparam logic [1:0] FRAC_STEP_FIRST  = 2'h0;
  localparam logic [1:0] FRAC_STEP_SECOND = 2'h1;
  localparam logic [1:0] FRAC_STEP_THIRD  = 2'h2;

  // Status register bit positions
  localparam int FRAC_ST_BUSY     = 0;
  localparam int FRAC_ST_BURN_REF = 1;
  localparam int FRAC_ST_READ_REF = 2;
  localparam int FRAC_ST_PASS     = 3;
  localparam int FRAC_ST_FAIL     = 4;
  localparam int FRAC_ST_SLEEP    = 5;
  localparam int FRAC_ST_LOCKED   = 6;
  localparam int FRAC_ST_CMD_REF  = 7;

  // Fuse array layout
  localparam int FRAC_FUSE_BITS    = 128;
  localparam int FRAC_SECRET_BITS  = 64;
  localparam int FRAC_STATUS_LSB   = 64;
  localparam int FRAC_LOCK_BIT     = 87;
  localparam int FRAC_MAKER_LSB    = 88;
  localparam int FRAC_SERIAL_LSB   = 96;
  localparam int FRAC_BURN_BITS    = 88;   // Fuses 0..87 reachable by a burn
  localparam int FRAC_SECRET_WORDS = 2;    // Fuse read words 0 and 1 are secret

  // ROM layout: number of readable words
  localparam int FRAC_ROM_READ_WORDS = 2;  // First 64 bits only

  // Factory value of an unburned user fuse
  localparam logic FRAC_FUSE_BLANK = 1'b1;

  // Watchdog interval, free choice of the block, and its cycle count
  localparam int          FRAC_CLK_MHZ      = 125;
  localparam int          FRAC_WDOG_TIME_MS = 1300;
  localparam logic [31:0] FRAC_WDOG_CYCLES  = 32'(FRAC_WDOG_TIME_MS * FRAC_CLK_MHZ * 1000);

endpackage

// ---- hw/frac_fuse_bank.sv ----
// One-time fuse bank: burn-only storage with a registered word read port.
// Assumes burn requests are one-cycle pulses from logic on the same clock.
`timescale 1ns/10ps

module frac_fuse_bank
  import frac_pkg::*;
#(
  parameter int                 WIDTH   = FRAC_FUSE_BITS,
  parameter int                 WORD    = 32,
  parameter logic [WIDTH-1:0]   FACTORY = {WIDTH{FRAC_FUSE_BLANK}}
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [WIDTH-1:0]           burn_i,
  input  wire logic                       rd_en_i,
  input  wire logic [$clog2(WIDTH/WORD)-1:0] rd_idx_i,
  output logic      [WORD-1:0]            rd_data_o,
  output logic      [WIDTH-1:0]           fuses_o
);

  generate
    if (WIDTH % WORD != 0 || WIDTH < 2 * WORD) begin : g_bad
      $error("frac_fuse_bank: WIDTH must be a multiple of WORD, at least two words");
    end
  endgenerate

  logic [WIDTH-1:0] cell_q;

  // A burn only clears cells; only a reset brings a burned fuse back to its factory one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cell_q <= FACTORY;
    end else begin
      cell_q <= cell_q & ~burn_i;
    end
  end

  // Word read port comes out of a register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= cell_q[rd_idx_i*WORD +: WORD];
    end
  end

  assign fuses_o = cell_q;

endmodule

// ---- hw/frac_top.sv ----
// Fuse and mask ROM access control with a Wishbone register port.
// Assumes a classic Wishbone master on CLK_SYS_I; no pins cross domains.
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps

module frac_top
  import frac_pkg::*;
#(
  parameter logic [31:0] WDOG_CYCLES     = FRAC_WDOG_CYCLES,
  parameter logic [15:0] ROM_MAKER_CODE  = 16'h3c5a,     // Arbitrary identity value
  parameter logic [15:0] WAFER_SERIAL    = 16'h0001,     // Arbitrary per-die value
  parameter logic [31:0] REVISION        = 32'h00000001, // Arbitrary revision value
  parameter logic [7:0]  FUSE_MAKER_CODE = 8'h5c,        // Arbitrary identity value
  parameter logic [31:0] FUSE_SERIAL     = 32'h00000001, // Arbitrary per-part value
  parameter logic [31:0] MASK_KEY        = 32'h6b43a9e1  // Mask-programmed key
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             SLEEP_O,
  output logic             VALID_PASS_O,
  output logic      [47:0] SERIAL_NUM_O
);

  generate
    if (WDOG_CYCLES < 32'd2) begin : g_bad_wdog
      $error("frac_top: WDOG_CYCLES must be at least 2");
    end
  endgenerate

  // Factory image of the fuse array: user fuses blank, identity fuses set
  localparam logic [FRAC_FUSE_BITS-1:0] FACTORY_FUSES =
    {FUSE_SERIAL, FUSE_MAKER_CODE, {FRAC_BURN_BITS{FRAC_FUSE_BLANK}}};

  // Fuses a burn can reach; identity fuses are masked off for good
  localparam logic [FRAC_FUSE_BITS-1:0] BURNABLE =
    {{(FRAC_FUSE_BITS-FRAC_BURN_BITS){1'b0}}, {FRAC_BURN_BITS{1'b1}}};

  // Readable mask ROM image, 64 bits as two words
  localparam logic [63:0] ROM_IMAGE = {REVISION, WAFER_SERIAL, ROM_MAKER_CODE};

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FREAD = 4'b0010,
    ST_FCAP  = 4'b0100,
    ST_SLEEP = 4'b1000
  } frac_state_e;

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Keyed mixing round used by the validation steps
  function automatic logic [31:0] mix(input logic [31:0] a, input logic [31:0] k);
    logic [31:0] sum;
    sum = a + k;
    return {a[26:0], a[31:27]} ^ sum ^ {sum[15:0], sum[31:16]};
  endfunction

  // Bus side signals
  logic                       ack_q;
  logic [31:0]                dat_q;
  logic                       bus_req;
  logic                       wr_acc;
  logic                       rd_acc;

  // Software registers
  logic [FRAC_BURN_BITS-1:0]  burn_mask_q;
  logic [31:0]                chal_q;
  logic [31:0]                resp_q;
  logic                       cmd_go_q;
  logic [3:0]                 cmd_op_q;
  logic [1:0]                 cmd_arg_q;

  // Block state
  frac_state_e                state_q;
  logic [31:0]                result_q;
  logic                       burn_ref_q;
  logic                       read_ref_q;
  logic                       cmd_ref_q;
  logic                       pass_q;
  logic                       fail_q;
  logic [31:0]                acc_q;
  logic [31:0]                wdog_q;
  logic                       wdog_fire;
  logic [47:0]                serial_q;

  // Fuse bank connection
  logic [FRAC_FUSE_BITS-1:0]  burn_vec;
  logic [FRAC_FUSE_BITS-1:0]  fuses;
  logic                       fuse_rd_en;
  logic [31:0]                fuse_rd_data;
  logic                       locked;
  logic [63:0]                secret_eff;
  logic                       awake;

  assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr_acc  = bus_req && WB_WE_I;
  assign rd_acc  = bus_req && !WB_WE_I;
  assign awake   = (state_q != ST_SLEEP);

  // A burned lock fuse reads zero
  assign locked = (fuses[FRAC_LOCK_BIT] != FRAC_FUSE_BLANK);

  // Secret fuses count only after the lock fuse is burned
  assign secret_eff = locked ? fuses[FRAC_SECRET_BITS-1:0] : 64'h0;

  // Wishbone answer: one wait state, ack dropped the cycle after it rose
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Read mux; unmapped offsets answer zero rather than an error
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dat_q <= 32'h0;
    end else if (rd_acc) begin
      unique case (WB_ADR_I)
        FRAC_OFS_CMD:    dat_q <= {22'h0, cmd_arg_q, 4'h0, cmd_op_q};
        FRAC_OFS_BURN0:  dat_q <= burn_mask_q[31:0];
        FRAC_OFS_BURN1:  dat_q <= burn_mask_q[63:32];
        FRAC_OFS_BURN2:  dat_q <= {8'h0, burn_mask_q[87:64]};
        FRAC_OFS_CHAL:   dat_q <= chal_q;
        FRAC_OFS_RESP:   dat_q <= 32'h0;  // Response is write-only
        FRAC_OFS_RESULT: dat_q <= result_q;
        FRAC_OFS_STATUS: begin
          dat_q                   <= 32'h0;
          dat_q[FRAC_ST_BUSY]     <= (state_q == ST_FREAD) || (state_q == ST_FCAP) || cmd_go_q;
          dat_q[FRAC_ST_BURN_REF] <= burn_ref_q;
          dat_q[FRAC_ST_READ_REF] <= read_ref_q;
          dat_q[FRAC_ST_PASS]     <= pass_q;
          dat_q[FRAC_ST_FAIL]     <= fail_q;
          dat_q[FRAC_ST_SLEEP]    <= !awake;
          dat_q[FRAC_ST_LOCKED]   <= locked;
          dat_q[FRAC_ST_CMD_REF]  <= cmd_ref_q;
        end
        FRAC_OFS_SERLO:  dat_q <= serial_q[31:0];
        FRAC_OFS_SERHI:  dat_q <= {16'h0, serial_q[47:32]};
        default:         dat_q <= 32'h0;
      endcase
    end
  end

  // Burn selection: any subset of secret and status fuses plus the lock
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      burn_mask_q <= '0;
    end else if (wr_acc) begin
      if (WB_ADR_I == FRAC_OFS_BURN0) begin
        burn_mask_q[31:0] <= lane_merge(burn_mask_q[31:0], WB_DAT_I, WB_SEL_I);
      end
      if (WB_ADR_I == FRAC_OFS_BURN1) begin
        burn_mask_q[63:32] <= lane_merge(burn_mask_q[63:32], WB_DAT_I, WB_SEL_I);
      end
      if (WB_ADR_I == FRAC_OFS_BURN2) begin
        burn_mask_q[87:64] <= 24'(lane_merge({8'h0, burn_mask_q[87:64]}, WB_DAT_I, WB_SEL_I));
      end
    end
  end

  // Challenge and response words for validation
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      chal_q <= 32'h0;
      resp_q <= 32'h0;
    end else if (wr_acc) begin
      if (WB_ADR_I == FRAC_OFS_CHAL) begin
        chal_q <= lane_merge(chal_q, WB_DAT_I, WB_SEL_I);
      end
      if (WB_ADR_I == FRAC_OFS_RESP) begin
        resp_q <= lane_merge(resp_q, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // Command strobe: a write to the command word with lane 0 launches it
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmd_go_q  <= 1'b0;
      cmd_op_q  <= 4'h0;
      cmd_arg_q <= 2'h0;
    end else begin
      cmd_go_q <= wr_acc && (WB_ADR_I == FRAC_OFS_CMD) && WB_SEL_I[0];
      if (wr_acc && (WB_ADR_I == FRAC_OFS_CMD)) begin
        if (WB_SEL_I[0]) begin
          cmd_op_q <= WB_DAT_I[FRAC_CMD_OP_LSB +: 4];
        end
        if (WB_SEL_I[1]) begin
          cmd_arg_q <= WB_DAT_I[FRAC_CMD_ARG_LSB +: 2];
        end
      end
    end
  end

  // Watchdog: restarts only on wake and ignores all other traffic
  assign wdog_fire = awake && (wdog_q == WDOG_CYCLES - 32'd1);

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wdog_q <= 32'h0;
    end else if (!awake) begin
      wdog_q <= 32'h0;
    end else if (!wdog_fire) begin
      wdog_q <= wdog_q + 32'd1;
    end
  end

  // Command sequencer; the watchdog wins over any command in flight
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
    end else if (wdog_fire) begin
      state_q <= ST_SLEEP;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cmd_go_q && cmd_op_q == FRAC_OP_FUSE_READ &&
              cmd_arg_q >= 2'(FRAC_SECRET_WORDS)) begin
            state_q <= ST_FREAD;
          end
        end
        ST_FREAD: state_q <= ST_FCAP;
        ST_FCAP:  state_q <= ST_IDLE;
        ST_SLEEP: begin
          if (cmd_go_q && cmd_op_q == FRAC_OP_WAKE) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Fuse read port request, launched only for public words
  assign fuse_rd_en = (state_q == ST_FREAD);

  // Burn pulse: refused once locked, identity fuses never reachable
  always_comb begin
    burn_vec = '0;
    if (cmd_go_q && awake && cmd_op_q == FRAC_OP_BURN && !locked) begin
      burn_vec = {{(FRAC_FUSE_BITS-FRAC_BURN_BITS){1'b0}}, burn_mask_q} & BURNABLE;
    end
  end

  // Result word: fuse reads, ROM reads; secret and hidden data read as zero
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      result_q <= 32'h0;
    end else if (state_q == ST_FCAP) begin
      result_q <= fuse_rd_data;
    end else if (cmd_go_q && awake) begin
      unique case (cmd_op_q)
        FRAC_OP_FUSE_READ: begin
          result_q <= 32'h0;
        end
        FRAC_OP_ROM_READ: begin
          if (cmd_arg_q < 2'(FRAC_ROM_READ_WORDS)) begin
            // Byte 0 carries the low byte, so a byte-serial wire shows it swapped
            result_q <= ROM_IMAGE[cmd_arg_q[0]*32 +: 32];
          end else begin
            result_q <= 32'h0;
          end
        end
        default: result_q <= result_q;
      endcase
    end
  end

  // Refusal flags report the fate of the latest command only
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      burn_ref_q <= 1'b0;
      read_ref_q <= 1'b0;
      cmd_ref_q  <= 1'b0;
    end else if (cmd_go_q) begin
      cmd_ref_q  <= !awake && (cmd_op_q != FRAC_OP_WAKE);
      burn_ref_q <= awake && (cmd_op_q == FRAC_OP_BURN) && locked;
      read_ref_q <= awake && (((cmd_op_q == FRAC_OP_FUSE_READ) &&
                               (cmd_arg_q < 2'(FRAC_SECRET_WORDS))) ||
                              ((cmd_op_q == FRAC_OP_ROM_READ) &&
                               (cmd_arg_q >= 2'(FRAC_ROM_READ_WORDS))));
    end
  end

  // Validation chain: maker code always in, ROM serial and status fuses never
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc_q  <= 32'h0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (!awake) begin
      acc_q  <= 32'h0;  // Sleep drops any half-built digest
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (cmd_go_q && cmd_op_q == FRAC_OP_VALIDATE) begin
      unique case (cmd_arg_q)
        FRAC_STEP_FIRST: begin
          acc_q  <= mix(chal_q ^ {fuses[FRAC_MAKER_LSB +: 8], 8'h0, ROM_MAKER_CODE}, MASK_KEY);
          pass_q <= 1'b0;
          fail_q <= 1'b0;
        end
        FRAC_STEP_SECOND: begin
          acc_q <= mix(acc_q ^ chal_q, MASK_KEY);
        end
        FRAC_STEP_THIRD: begin
          // Only the verdict leaves the block, never the expected value
          pass_q <= (mix(acc_q ^ secret_eff[31:0] ^ secret_eff[63:32], MASK_KEY)
                     == resp_q);
          fail_q <= (mix(acc_q ^ secret_eff[31:0] ^ secret_eff[63:32], MASK_KEY)
                     != resp_q);
        end
        default: begin
          pass_q <= 1'b0;  // An unknown step never leaves a stale pass behind
          fail_q <= 1'b1;
        end
      endcase
    end
  end

  // Full serial number from ROM and fuse parts
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      serial_q <= 48'h0;
    end else begin
      serial_q <= {WAFER_SERIAL, fuses[FRAC_SERIAL_LSB +: 32]};
    end
  end

  // Fuse storage
  frac_fuse_bank #(
    .WIDTH   (FRAC_FUSE_BITS),
    .WORD    (32),
    .FACTORY (FACTORY_FUSES)
  ) u_bank (
    .clk_i     (CLK_SYS_I),
    .rst_n_i   (RST_N_I),
    .burn_i    (burn_vec),
    .rd_en_i   (fuse_rd_en),
    .rd_idx_i  (cmd_arg_q),
    .rd_data_o (fuse_rd_data),
    .fuses_o   (fuses)
  );

  // Registered outputs
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SLEEP_O      <= 1'b0;
      VALID_PASS_O <= 1'b0;
    end else begin
      SLEEP_O      <= wdog_fire || !awake;
      VALID_PASS_O <= pass_q;
    end
  end

  assign WB_DAT_O     = dat_q;
  assign WB_ACK_O     = ack_q;
  assign SERIAL_NUM_O = serial_q;

endmodule

// ---- sim/frac_wb_host.sv ----
// Classic Wishbone master standing for the host microcontroller.
// Assumes a slave that answers within 16 cycles; one transfer at a time.
`timescale 1ns/10ps

module frac_wb_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [31:0] dat_o
);
  // Idle bus from time zero so the slave never sees a stray strobe
  initial begin
    {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
  end

  // Request held from launch edge to ack edge and dropped there, so the
  // next call waits an edge first and the bus idles at least one cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    ok = 1'b0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_i);
      ok = ack_i;
    end
    q = dat_i;
    {cyc_o, stb_o, we_o} <= 3'b000;
  endtask
endmodule

// ---- sim/frac_top_props.sv ----
// Concurrent checks on the ports of the fuse and ROM access block.
// Assumes one clock domain and a classic Wishbone master on the port.
`timescale 1ns/10ps

module frac_top_props
  import frac_pkg::*;
#(
  parameter logic [31:0] WDOG_CYCLES  = FRAC_WDOG_CYCLES,
  parameter logic [15:0] WAFER_SERIAL = 16'h0001,
  parameter logic [31:0] FUSE_SERIAL  = 32'h00000001
) (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        SLEEP_O,
  input wire logic        VALID_PASS_O,
  input wire logic [47:0] SERIAL_NUM_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  logic        take;
  logic        cmd_wr;
  logic [31:0] idle_q;
  assign take   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign cmd_wr = take && WB_WE_I && WB_ADR_I == FRAC_OFS_CMD;

  // Cycles since any command write; counts no more than the watchdog,
  // which only a wake command restarts, so the bound stays safe
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) idle_q <= 32'h0;
    else if (cmd_wr) idle_q <= 32'h0;
    else if (idle_q != 32'hffffffff) idle_q <= idle_q + 32'h1;
  end

  a_ack_next: assert property (take |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(take))
    else $error("ack without request");
  a_serial_fixed: assert property ($past(RST_N_I) |-> SERIAL_NUM_O == {WAFER_SERIAL, FUSE_SERIAL})
    else $error("serial number wrong");
  a_resp_hidden: assert property (take && !WB_WE_I && WB_ADR_I == FRAC_OFS_RESP |=> WB_DAT_O == 32'h0)
    else $error("response register readable");
  a_dat_hold: assert property (!(take && !WB_WE_I) |=> $stable(WB_DAT_O))
    else $error("read data moved without a read");
  a_wake_only: assert property ($fell(SLEEP_O) |-> $past(cmd_wr) || $past(cmd_wr, 2) || $past(cmd_wr, 3))
    else $error("left sleep without command");
  a_wdog_sleep: assert property (idle_q > WDOG_CYCLES + 32'd8 |-> SLEEP_O)
    else $error("watchdog did not force sleep");

  c_sleep: cover property ($rose(SLEEP_O));
  c_cmd: cover property (cmd_wr);
  c_read: cover property (take && !WB_WE_I ##1 WB_ACK_O);
endmodule

bind frac_top frac_top_props #(
  .WDOG_CYCLES(WDOG_CYCLES), .WAFER_SERIAL(WAFER_SERIAL), .FUSE_SERIAL(FUSE_SERIAL)
) i_frac_top_props (.CLK_SYS_I, .RST_N_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .SLEEP_O, .VALID_PASS_O, .SERIAL_NUM_O);

// ---- sim/frac_top_test.sv ----
// Self-checking bench for the fuse and ROM access block.
// Assumes the host model drives the Wishbone port; notes retire on read acks.
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin failures++; \
  $display("mismatch %s exp %h seen %h", n, e, s); end end

module frac_top_test;
  import frac_pkg::*;
  localparam logic [31:0] WDOG = 32'd3000;  // Short watchdog for simulation
  localparam logic [15:0] RM   = 16'h4d2e;  // Arbitrary identity value
  localparam logic [7:0]  FM   = 8'ha7;     // Arbitrary identity value
  localparam logic [15:0] WS   = 16'h1357;
  localparam logic [31:0] FS   = 32'h2468ace0;
  localparam logic [31:0] RV   = 32'h00000003;
  localparam logic [31:0] KEY  = 32'h1f2e3d4c;  // Arbitrary mask key for the bench
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc, stb, we, ack, slp, pass;
  logic [7:0]  adr;
  logic [31:0] dw, dr, q, r;
  logic [47:0] sn;
  logic [23:0] st = '1;  // Fuses 87:64 as they should stand
  logic [63:0] sec = '1;  // Secret fuses 63:0 as they should stand
  logic [31:0] eq[$], mq[$];
  string       nq[$];
  int          failures = 0;
  int          checked = 0;
  bit          ok;

  always #4 clk = ~clk;

  frac_top #(.WDOG_CYCLES(WDOG), .ROM_MAKER_CODE(RM), .WAFER_SERIAL(WS), .REVISION(RV),
    .FUSE_MAKER_CODE(FM), .FUSE_SERIAL(FS), .MASK_KEY(KEY)) i_frac_top (.CLK_SYS_I(clk),
    .RST_N_I(rst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .SLEEP_O(slp), .VALID_PASS_O(pass),
    .SERIAL_NUM_O(sn));
  frac_wb_host i_frac_wb_host (.clk_i(clk), .ack_i(ack), .dat_i(dr), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(dw));

  // Each read answer retires the oldest note; the mask picks the bits that matter
  always @(posedge clk) begin
    if (ack && !we && mq.size() > 0) begin
      `CHK(nq[0], eq[0] & mq[0], dr & mq[0])
      void'(eq.pop_front());
      void'(mq.pop_front());
      void'(nq.pop_front());
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A transfer that never gets its ack counts as a mismatch and ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_frac_wb_host.xfer(1'b1, a, d, q, ok);
    if (!ok) begin failures++; close_out(); end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input string n);
    eq.push_back(e);
    mq.push_back(m);
    nq.push_back(n);
    i_frac_wb_host.xfer(1'b0, a, 32'h0, q, ok);
    if (!ok) begin failures++; close_out(); end
  endtask
  // Fixed settle time: every result lands within five cycles of the write
  task automatic cmd(input logic [3:0] op, input logic [1:0] arg);
    wr(FRAC_OFS_CMD, {22'h0, arg, 4'h0, op});
    repeat (6) @(posedge clk);
  endtask
  task automatic burn(input logic [31:0] b2);
    logic [63:0] b;
    b = {$urandom, $urandom};
    wr(FRAC_OFS_BURN0, b[31:0]);
    wr(FRAC_OFS_BURN1, b[63:32]);
    wr(FRAC_OFS_BURN2, b2);
    cmd(FRAC_OP_BURN, 2'h0);
    // Secrets only move while the lock fuse is still blank
    if (st[23]) begin
      sec = sec & ~b;
    end
  endtask
  // Bench model of the keyed mixing round the digest chain is built from
  function automatic logic [31:0] vmix(input logic [31:0] a, input logic [31:0] k);
    logic [31:0] s;
    s = a + k;
    return {a[26:0], a[31:27]} ^ s ^ {s[15:0], s[31:16]};
  endfunction
  // Three validation steps; a bad response differs in bit 0 only
  task automatic validate(input logic [63:0] s, input logic good, input string n);
    logic [31:0] c;
    logic [31:0] a;
    c = $urandom;
    a = vmix(vmix(c ^ {FM, 8'h0, RM}, KEY) ^ c, KEY);
    a = vmix(a ^ s[31:0] ^ s[63:32], KEY) ^ {31'h0, !good};
    wr(FRAC_OFS_CHAL, c);
    cmd(FRAC_OP_VALIDATE, FRAC_STEP_FIRST);
    cmd(FRAC_OP_VALIDATE, FRAC_STEP_SECOND);
    wr(FRAC_OFS_RESP, a);
    cmd(FRAC_OP_VALIDATE, FRAC_STEP_THIRD);
    rd(FRAC_OFS_STATUS, good ? 32'h8 : 32'h10, 32'h18, n);
    `CHK(n, good, pass)
  endtask

  initial begin
    r = $urandom(96);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("serial", {WS, FS}, sn)
    rd(FRAC_OFS_SERLO, FS, '1, "serlo");
    rd(FRAC_OFS_SERHI, {16'h0, WS}, '1, "serhi");
    // Secret words refused and empty; public words show blank status and factory codes
    for (int w = 0; w < 4; w++) begin
      cmd(FRAC_OP_FUSE_READ, 2'(w));
      rd(FRAC_OFS_RESULT, w == 2 ? {FM, st} : w == 3 ? FS : 32'h0, '1, "fuse");
      rd(FRAC_OFS_STATUS, {29'h0, w < 2, 2'h0}, 32'h4, "fuse ref");
    end
    for (int w = 0; w < 4; w++) begin
      cmd(FRAC_OP_ROM_READ, 2'(w));
      rd(FRAC_OFS_RESULT, w == 0 ? {WS, RM} : w == 1 ? RV : 32'h0, '1, "rom");
      rd(FRAC_OFS_STATUS, {29'h0, w > 1, 2'h0}, 32'h4, "rom ref");
    end
    wr(FRAC_OFS_RESP, $urandom);
    rd(FRAC_OFS_RESP, 32'h0, '1, "resp");
    $display("test done: reads");
    // Overlapping random burns; a burned fuse never comes back, maker lanes ignored
    repeat (2) begin
      r = $urandom & 32'hff7fffff;
      burn(r);
      st = st & ~r[23:0];
      rd(FRAC_OFS_STATUS, 32'h0, 32'h42, "burn ok");
      cmd(FRAC_OP_FUSE_READ, 2'h2);
      rd(FRAC_OFS_RESULT, {FM, st}, '1, "burned");
    end
    validate(64'h0, 1'b1, "open pass");
    burn(32'h00800000);
    st[23] = 1'b0;
    rd(FRAC_OFS_STATUS, 32'h40, 32'h42, "lock");
    burn($urandom | 32'h1);
    rd(FRAC_OFS_STATUS, 32'h42, 32'h42, "burn ref");
    cmd(FRAC_OP_FUSE_READ, 2'h2);
    rd(FRAC_OFS_RESULT, {FM, st}, '1, "locked");
    validate(sec, 1'b1, "keyed pass");
    validate(sec, 1'b0, "wrong resp");
    cmd(FRAC_OP_VALIDATE, 2'h3);
    rd(FRAC_OFS_STATUS, 32'h10, 32'h18, "bad step");
    `CHK("pass", 1'b0, pass)
    $display("test done: burns");
    for (int n = 0; n < 4000 && slp !== 1'b1; n++) @(posedge clk);
    `CHK("sleep", 1'b1, slp)
    if (slp !== 1'b1) close_out();
    cmd(FRAC_OP_ROM_READ, 2'h0);
    rd(FRAC_OFS_STATUS, 32'ha0, 32'ha0, "asleep");
    cmd(FRAC_OP_WAKE, 2'h0);
    `CHK("wake", 1'b0, slp)
    $display("test done: watchdog");
    close_out();
  end
endmodule
